// ---- inc/vsf_consts.svh ----
// Purpose: offsets, field positions, reset values and limits of the filter select block
// Assumes: apb with 32-bit data, word-aligned byte offsets
// Notes: included by the design only; the package does not include it
`ifndef VSF_CONSTS_SVH
`define VSF_CONSTS_SVH

// register byte offsets
`define VSF_OFF_ADAPT_MODE   12'h000
`define VSF_OFF_SWITCH_MODE  12'h004
`define VSF_OFF_STATUS       12'h008
`define VSF_OFF_ADAPT_RESULT 12'h00c
`define VSF_OFF_NOTCH_BASE   12'h010
`define VSF_OFF_DAMP_BASE    12'h020

// notch register field positions: freq [12:0], width [20:16], depth [30:24]
`define VSF_NOTCH_FREQ_LSB   0
`define VSF_NOTCH_WIDTH_LSB  16
`define VSF_NOTCH_DEPTH_LSB  24

// adaptive result fields: freq [12:0], width [20:16], depth [30:24], valid [31]
`define VSF_RESULT_VALID_BIT 31

// reset values and limits
`define VSF_ADAPT_MODE_RST   3'h0
`define VSF_ADAPT_MODE_MAX   3'h4
`define VSF_SWITCH_MODE_RST  2'h0
`define VSF_NOTCH_FREQ_RST   13'h1388
`define VSF_NOTCH_FREQ_MIN   13'h0032
`define VSF_NOTCH_FREQ_MAX   13'h1388
`define VSF_NOTCH_WIDTH_RST  5'h02
`define VSF_NOTCH_WIDTH_MAX  5'h14
`define VSF_NOTCH_DEPTH_RST  7'h00
`define VSF_NOTCH_DEPTH_MAX  7'h63
`define VSF_DAMP_FREQ_RST    11'h000
`define VSF_DAMP_FREQ_MAX    11'h7d0
`define VSF_DAMP_FREQ_ON     11'h00a

`endif

// ---- inc/vsf_pkg.sv ----
// Purpose: types of the filter select block
// Assumes: vsf_consts.svh defines the numbers
// Notes: types only
package vsf_pkg;

    // damping filter switching modes
    typedef enum logic [1:0] {
        VSF_SW_ALWAYS = 2'h0,
        VSF_SW_INPUT_A = 2'h1,
        VSF_SW_DECODE = 2'h2,
        VSF_SW_DIRECTION = 2'h3
    } vsf_switch_mode_t;

    // adaptive bank state, one-hot
    typedef enum logic [2:0] {
        VSF_AD_OFF = 3'h1,
        VSF_AD_TRACK = 3'h2,
        VSF_AD_LOCKED = 3'h4
    } vsf_adapt_state_t;

endpackage : vsf_pkg

// ---- verilog/vsf_filter_select.sv ----
// Purpose: configuration and selection of notch and damping filters
// Assumes: apb slave on pclk, adaptive engine outside reports results
// Notes: filter arithmetic lives elsewhere; this block holds settings
//
// Functional notes
// - adaptive mode 0 to 4, 0 off
// - mode 1: one notch, freeze after converge
// - mode 2: two notches, freeze after converge
// - mode 3: one notch, always adapting
// - mode 4: two notches, one always adapting
// - notch frequency 50 to 5000 Hz, default 5000
// - notch width 0 to 20, default 2
// - notch depth 0 to 99, default 0
// - adaptive results overwrite notches 3 and 4
// - switching mode 0 to 3, 0 all enabled
// - mode 1: input a picks 1+3 or 2+4
// - mode 2: inputs decode one filter
// - mode 3: direction picks 1+3 or 2+4
// - damping 1 frequency 0.1 Hz, active at 10+
// - damping 2 to 4 likewise, active at 10+
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "vsf_consts.svh"

module vsf_filter_select
    import vsf_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // selection pins and motion direction
    input wire logic damping_select_input_a,
    input wire logic damping_select_input_b,
    input wire logic motion_reverse,
    // adaptive engine results, one-cycle strobes per notch
    input wire logic adapt_update_3,
    input wire logic adapt_update_4,
    input wire logic adapt_converged,
    input wire logic [12:0] adapt_freq,
    input wire logic [4:0] adapt_width,
    input wire logic [6:0] adapt_depth,
    // outputs to filter datapath
    output logic [3:0] notch_adaptive,
    output logic [3:0] notch_tracking,
    output logic [3:0] damping_enable
);

    localparam int NOTCHES = 4;
    localparam int DAMPERS = 4;

    logic [2:0] adapt_mode;
    vsf_switch_mode_t switch_mode;
    logic [12:0] notch_freq [NOTCHES];
    logic [4:0] notch_width [NOTCHES];
    logic [6:0] notch_depth [NOTCHES];
    logic [10:0] damp_freq [DAMPERS];
    logic sel_a_meta, sel_a_sync, sel_b_meta, sel_b_sync;
    logic dir_meta, dir_sync;
    vsf_adapt_state_t adapt_state;
    logic [1:0] adapt_count;
    logic wr_access, rd_access;
    logic [3:0] next_damping_enable;
    logic [3:0] next_notch_adaptive;
    logic [3:0] next_notch_tracking;
    logic [31:0] next_prdata;
    logic next_slverr;
    logic addr_ok;

    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & ~penable & ~pwrite;

    // two-stage synchronisers, pin level high means shorted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_a_meta <= 1'b0;
            sel_a_sync <= 1'b0;
            sel_b_meta <= 1'b0;
            sel_b_sync <= 1'b0;
            dir_meta <= 1'b0;
            dir_sync <= 1'b0;
        end else begin
            sel_a_meta <= damping_select_input_a;
            sel_a_sync <= sel_a_meta;
            sel_b_meta <= damping_select_input_b;
            sel_b_sync <= sel_b_meta;
            dir_meta <= motion_reverse;
            dir_sync <= dir_meta;
        end
    end

    // adaptive mode register; out-of-range writes are refused
    // a refused write leaves the old mode running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adapt_mode <= `VSF_ADAPT_MODE_RST;
        end else if (wr_access && paddr == `VSF_OFF_ADAPT_MODE
                     && pwdata[2:0] <= `VSF_ADAPT_MODE_MAX && pwdata[31:3] == 29'h0) begin
            adapt_mode <= pwdata[2:0];
        end
    end

    // switching mode register, all four codes legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_mode <= vsf_switch_mode_t'(`VSF_SWITCH_MODE_RST);
        end else if (wr_access && paddr == `VSF_OFF_SWITCH_MODE) begin
            switch_mode <= vsf_switch_mode_t'(pwdata[1:0]);
        end
    end

    // adaptive bank state: tracking until converged, modes 1, 2 and 4 then lock
    // a change to mode 0 or 3 drops the lock so tracking starts afresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adapt_state <= VSF_AD_OFF;
        end else begin
            case (adapt_state)
                VSF_AD_OFF: begin
                    if (adapt_mode != 3'h0) begin
                        adapt_state <= VSF_AD_TRACK;
                    end
                end
                VSF_AD_TRACK: begin
                    if (adapt_mode == 3'h0) begin
                        adapt_state <= VSF_AD_OFF;
                    end else if (adapt_converged && (adapt_mode == 3'h1
                                 || adapt_mode == 3'h2 || adapt_mode == 3'h4)) begin
                        adapt_state <= VSF_AD_LOCKED;
                    end
                end
                VSF_AD_LOCKED: begin
                    if (adapt_mode == 3'h0 || adapt_mode == 3'h3) begin
                        adapt_state <= VSF_AD_OFF;
                    end
                end
                default: begin
                    adapt_state <= VSF_AD_OFF;
                end
            endcase
        end
    end

    // number of adaptive notches for the current mode
    always_comb begin
        case (adapt_mode)
            3'h1: adapt_count = 2'h1;
            3'h2: adapt_count = 2'h2;
            3'h3: adapt_count = 2'h1;
            3'h4: adapt_count = 2'h2;
            default: adapt_count = 2'h0;
        endcase
    end

    // notch flags: notch 3 is first adaptive, notch 4 second
    always_comb begin
        next_notch_adaptive = 4'h0;
        next_notch_tracking = 4'h0;
        next_notch_adaptive[2] = (adapt_count != 2'h0);
        next_notch_adaptive[3] = (adapt_count == 2'h2);
        if (adapt_state == VSF_AD_TRACK) begin
            next_notch_tracking[2] = next_notch_adaptive[2];
            next_notch_tracking[3] = next_notch_adaptive[3];
        end else if (adapt_state == VSF_AD_LOCKED && adapt_mode == 3'h4) begin
            // in mode 4 the first notch keeps adapting once the second has settled
            next_notch_tracking[2] = 1'b1;
        end
    end

    // per-notch settings; adaptive results win over software writes
    // notches 1 and 2 never take results, their load is tied low
    generate
        for (genvar n = 0; n < NOTCHES; n++) begin : g_notch
            logic hw_load;
            if (n >= 2) begin : g_adapt
                assign hw_load = next_notch_tracking[n]
                    && ((n == 2) ? adapt_update_3 : adapt_update_4);
            end else begin : g_plain
                assign hw_load = 1'b0;
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    notch_freq[n] <= `VSF_NOTCH_FREQ_RST;
                    notch_width[n] <= `VSF_NOTCH_WIDTH_RST;
                    notch_depth[n] <= `VSF_NOTCH_DEPTH_RST;
                end else if (hw_load) begin
                    notch_freq[n] <= adapt_freq;
                    notch_width[n] <= adapt_width;
                    notch_depth[n] <= adapt_depth;
                end else if (wr_access && paddr == `VSF_OFF_NOTCH_BASE + 12'(4 * n)) begin
                    // out-of-range fields keep their old value
                    if (pwdata[12:0] >= `VSF_NOTCH_FREQ_MIN
                        && pwdata[12:0] <= `VSF_NOTCH_FREQ_MAX) begin
                        notch_freq[n] <= pwdata[12:0];
                    end
                    if (pwdata[20:16] <= `VSF_NOTCH_WIDTH_MAX) begin
                        notch_width[n] <= pwdata[20:16];
                    end
                    if (pwdata[30:24] <= `VSF_NOTCH_DEPTH_MAX) begin
                        notch_depth[n] <= pwdata[30:24];
                    end
                end
            end
        end
    endgenerate

    // damping frequency registers, 0.1 Hz steps
    generate
        for (genvar d = 0; d < DAMPERS; d++) begin : g_damp
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    damp_freq[d] <= `VSF_DAMP_FREQ_RST;
                end else if (wr_access && paddr == `VSF_OFF_DAMP_BASE + 12'(4 * d)
                             && pwdata[10:0] <= `VSF_DAMP_FREQ_MAX
                             && pwdata[31:11] == 21'h0) begin
                    damp_freq[d] <= pwdata[10:0];
                end
            end
        end
    endgenerate

    // damping filter selection, then gate by frequency threshold
    // a filter below the 1 Hz threshold stays off whatever the select says
    always_comb begin
        case (switch_mode)
            VSF_SW_ALWAYS: next_damping_enable = 4'hf;
            VSF_SW_INPUT_A: next_damping_enable = sel_a_sync ? 4'ha : 4'h5;
            VSF_SW_DECODE: begin
                case ({sel_b_sync, sel_a_sync})
                    2'h0: next_damping_enable = 4'h1;
                    2'h1: next_damping_enable = 4'h2;
                    2'h2: next_damping_enable = 4'h4;
                    default: next_damping_enable = 4'h8;
                endcase
            end
            VSF_SW_DIRECTION: next_damping_enable = dir_sync ? 4'ha : 4'h5;
            default: next_damping_enable = 4'h0;
        endcase
        for (int i = 0; i < DAMPERS; i++) begin
            if (damp_freq[i] < `VSF_DAMP_FREQ_ON) begin
                next_damping_enable[i] = 1'b0;
            end
        end
    end

    // damping enables registered so the datapath sees a glitch-free select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            damping_enable <= 4'h0;
        end else begin
            damping_enable <= next_damping_enable;
        end
    end

    // notch flags registered alongside, one edge after the mode or state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notch_adaptive <= 4'h0;
            notch_tracking <= 4'h0;
        end else begin
            notch_adaptive <= next_notch_adaptive;
            notch_tracking <= next_notch_tracking;
        end
    end

    // read mux, sampled in the setup cycle so data is ready at the access edge
    // unknown or misaligned offsets read as zero and answer with an error
    always_comb begin
        next_prdata = 32'h0;
        addr_ok = 1'b1;
        case (paddr)
            `VSF_OFF_ADAPT_MODE: next_prdata[2:0] = adapt_mode;
            `VSF_OFF_SWITCH_MODE: next_prdata[1:0] = switch_mode;
            `VSF_OFF_STATUS: begin
                next_prdata[3:0] = damping_enable;
                next_prdata[7:4] = notch_adaptive;
                next_prdata[11:8] = notch_tracking;
                next_prdata[12] = dir_sync;
                next_prdata[13] = sel_a_sync;
                next_prdata[14] = sel_b_sync;
                next_prdata[17:15] = adapt_state; // one-hot state, three bits
            end
            `VSF_OFF_ADAPT_RESULT: begin
                next_prdata[`VSF_RESULT_VALID_BIT] = (adapt_state == VSF_AD_LOCKED);
                next_prdata[30:0] = {notch_depth[2], 3'h0, notch_width[2], 3'h0, notch_freq[2]};
            end
            default: begin
                addr_ok = 1'b0;
                for (int i = 0; i < NOTCHES; i++) begin
                    if (paddr == `VSF_OFF_NOTCH_BASE + 12'(4 * i)) begin
                        addr_ok = 1'b1;
                        next_prdata = {1'b0, notch_depth[i], 3'h0, notch_width[i],
                                       3'h0, notch_freq[i]};
                    end
                end
                for (int i = 0; i < DAMPERS; i++) begin
                    if (paddr == `VSF_OFF_DAMP_BASE + 12'(4 * i)) begin
                        addr_ok = 1'b1;
                        next_prdata = {21'h0, damp_freq[i]};
                    end
                end
            end
        endcase
        next_slverr = ~addr_ok;
    end

    // ready: zero wait states, high for the access cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // error: unmapped offsets are answered but never written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & next_slverr;
        end
    end

    // read data captured in the setup cycle so it stands at the access edge;
    // it then holds until the next read, writes leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_access) begin
            prdata <= next_prdata;
        end
    end

endmodule : vsf_filter_select

// ---- tb/vsf_checker.sv ----
// Purpose: port assertions for the filter select block
// Assumes: one clock domain, async active-low reset
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
module vsf_checker (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // filter side
    input wire logic [3:0] notch_adaptive,
    input wire logic [3:0] notch_tracking,
    input wire logic [3:0] damping_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // setup and read-setup cycles
    wire setup = psel && !penable;
    wire rd_setup = setup && !pwrite;

    a_ready_after_setup: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready stood too long");
    a_ready_when_idle: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_err_unmapped: assert property (setup && paddr >= 12'h030 |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && paddr < 12'h030 && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // read data may only move after a read setup
    a_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved without a read");
    a_adapt_pattern: assert property (notch_adaptive inside {4'h0, 4'h4, 4'hc})
        else $error("bad adaptive notch pattern");
    a_track_subset: assert property ((notch_tracking & ~notch_adaptive) == 4'h0)
        else $error("tracking on a non-adaptive notch");

    c_unmapped: cover property (pready && pslverr);
    c_tracking: cover property ($rose(notch_tracking[3]));
    c_decode_four: cover property (damping_enable == 4'h8);
endmodule : vsf_checker

bind vsf_filter_select vsf_checker vsf_checker_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .notch_adaptive, .notch_tracking,
    .damping_enable);

// ---- tb/vsf_ctrl_model.sv ----
// Purpose: machine controller contacts feeding the selection pins
// Assumes: open contact reads 0, shorted reads 1
// Notes: contacts move just after a pclk edge, in step with the block's clock
`timescale 1ns/1ps
module vsf_ctrl_model (
    // clock
    input wire logic pclk,
    // wanted levels: {input b, input a, reverse}
    input wire logic [2:0] want,
    // contacts towards the block
    output logic damping_select_input_a,
    output logic damping_select_input_b,
    output logic motion_reverse
);
    // all contacts open and forward at power-up
    initial begin
        damping_select_input_a = 1'b0;
        damping_select_input_b = 1'b0;
        motion_reverse = 1'b0;
    end

    // contacts follow the wanted levels
    always @(posedge pclk) begin
        damping_select_input_a <= want[1];
        damping_select_input_b <= want[2];
        motion_reverse <= want[0];
    end
endmodule : vsf_ctrl_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the filter select block
// Assumes: apb slave answers whenever it raises ready
// Notes: expectations built from field limits and defaults
`timescale 1ns/1ps
module testbench;
    import vsf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic adapt_update_3, adapt_update_4, adapt_converged;
    logic [12:0] adapt_freq;
    logic [4:0] adapt_width;
    logic [6:0] adapt_depth;
    logic [3:0] notch_adaptive, notch_tracking, damping_enable;
    logic damping_select_input_a, damping_select_input_b, motion_reverse;
    logic [2:0] want;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    vsf_filter_select vsf_filter_select_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .damping_select_input_a,
        .damping_select_input_b, .motion_reverse, .adapt_update_3, .adapt_update_4,
        .adapt_converged, .adapt_freq, .adapt_width, .adapt_depth, .notch_adaptive,
        .notch_tracking, .damping_enable);
    vsf_ctrl_model vsf_ctrl_model_inst (.pclk, .want, .damping_select_input_a,
        .damping_select_input_b, .motion_reverse);

    // 25 ns clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic results;
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    // hang guard, far above the few hundred cycles used
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one apb transfer from the next edge; answer taken at the edge that sees ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdchk

    function automatic logic [31:0] nv(input logic [12:0] f, input logic [4:0] w,
        input logic [6:0] d);
        return {1'b0, d, 3'h0, w, 3'h0, f};
    endfunction : nv

    function automatic logic [3:0] sel_exp(input int m, input logic [2:0] p);
        case (m)
            0: return 4'hf;
            1: return p[1] ? 4'ha : 4'h5;
            2: return 4'h1 << {p[2], p[1]};
            default: return p[0] ? 4'ha : 4'h5;
        endcase
    endfunction : sel_exp

    // adaptive engine result strobe for notch 3 or 4
    task automatic upd(input logic four, input logic [12:0] f, input logic [4:0] w,
        input logic [6:0] d);
        adapt_freq <= f;
        adapt_width <= w;
        adapt_depth <= d;
        adapt_update_3 <= !four;
        adapt_update_4 <= four;
        @(posedge pclk);
        adapt_update_3 <= 1'b0;
        adapt_update_4 <= 1'b0;
        @(posedge pclk);
    endtask : upd

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, want} = '0;
        {adapt_update_3, adapt_update_4, adapt_converged} = '0;
        {adapt_freq, adapt_width, adapt_depth} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(damping_enable), 32'h0);
        rdchk(12'h000, 32'h0);
        rdchk(12'h004, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rdchk(12'(16 + 4 * i), nv(13'h1388, 5'h02, 7'h00));
            rdchk(12'(32 + 4 * i), 32'h0);
        end
        // field limits: out of range refused, edges taken
        apb(1'b1, 12'h010, nv(13'h0031, 5'h15, 7'h64));
        rdchk(12'h010, nv(13'h1388, 5'h02, 7'h00));
        apb(1'b1, 12'h010, nv(13'h0032, 5'h14, 7'h63));
        rdchk(12'h010, nv(13'h0032, 5'h14, 7'h63));
        apb(1'b1, 12'h014, nv(13'h1389, 5'h00, 7'h00));
        rdchk(12'h014, nv(13'h1388, 5'h00, 7'h00));
        apb(1'b1, 12'h000, 32'h5);
        rdchk(12'h000, 32'h0);
        apb(1'b1, 12'h030, 32'h1);
        check(32'(err), 32'h1);
        // damping frequency threshold at 10
        for (int i = 0; i < 4; i++) apb(1'b1, 12'(32 + 4 * i), 32'h9);
        repeat (3) @(posedge pclk);
        check(32'(damping_enable), 32'h0);
        for (int i = 0; i < 4; i++) apb(1'b1, 12'(32 + 4 * i), 32'ha);
        repeat (3) @(posedge pclk);
        check(32'(damping_enable), 32'hf);
        apb(1'b1, 12'h020, 32'h7d1);
        rdchk(12'h020, 32'ha);
        apb(1'b1, 12'h020, 32'h7d0);
        rdchk(12'h020, 32'h7d0);
        // every switching mode against every contact pattern
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 8; p++) begin
                apb(1'b1, 12'h004, 32'(m));
                want <= 3'(p);
                repeat (6) @(posedge pclk);
                check(32'(damping_enable), 32'(sel_exp(m, 3'(p))));
            end
        end
        apb(1'b1, 12'h02c, 32'h9);
        repeat (3) @(posedge pclk);
        check(32'(damping_enable), 32'h2);
        // adaptive modes, before and after convergence
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, 12'h000, 32'h0);
            repeat (3) @(posedge pclk);
            apb(1'b1, 12'h000, 32'(m));
            repeat (4) @(posedge pclk);
            check(32'(notch_adaptive), m == 0 ? 0 : (m % 2 == 0 ? 32'hc : 32'h4));
            check(32'(notch_tracking), m == 0 ? 0 : (m % 2 == 0 ? 32'hc : 32'h4));
            if (m == 2) begin
                upd(1'b0, 13'h03e8, 5'h05, 7'h1e);
                upd(1'b1, 13'h0320, 5'h07, 7'h28);
                rdchk(12'h018, nv(13'h03e8, 5'h05, 7'h1e));
                rdchk(12'h01c, nv(13'h0320, 5'h07, 7'h28));
            end
            adapt_converged <= 1'b1;
            @(posedge pclk);
            adapt_converged <= 1'b0;
            repeat (3) @(posedge pclk);
            check(32'(notch_tracking), m >= 3 ? 32'h4 : 32'h0);
            if (m == 2) rdchk(12'h00c, 32'h8000_0000 | nv(13'h03e8, 5'h05, 7'h1e));
        end
        apb(1'b1, 12'h000, 32'h0);
        repeat (3) @(posedge pclk);
        upd(1'b0, 13'h003c, 5'h01, 7'h01);
        rdchk(12'h018, nv(13'h03e8, 5'h05, 7'h1e));
        results();
    end
endmodule : testbench
